// file: src/scp_sensor_control.sv
// sensor control side: programming port, column pointer, output path, converter
// assumes every pin input (strobes, column and converter clocks) is synchronous
// to clock_i and that each of their levels lasts at least one clock cycle

`timescale 1ns/1ps
`default_nettype none

module scp_sensor_control #(
    parameter int PIX_W = 12,
    parameter int PTR_W = scp_pkg::BUS_W
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    // programming port
    input wire logic [scp_pkg::BUS_W-1:0] addr_data_i,
    input wire logic line_start_strobe_i,
    input wire logic column_start_strobe_i,
    input wire logic config_write_strobe_i,
    input wire logic config_reset_n_i,
    // readout controls
    input wire logic column_clock_i,
    input wire logic blank_i,
    input wire logic calibrate_i,
    input wire logic line_pointer_init_i,
    input wire logic line_read_advance_i,
    input wire logic line_reset_advance_i,
    input wire logic converter_clock_i,
    // values standing in for the analog sources
    input wire logic [PIX_W-1:0] pixel_value_i,
    input wire logic [PIX_W-1:0] temp_value_i,
    input wire logic [PIX_W-1:0] aux_analog_in_1_i,
    input wire logic [PIX_W-1:0] aux_analog_in_2_i,
    input wire logic [PIX_W-1:0] aux_analog_in_3_i,
    input wire logic [PIX_W-1:0] aux_analog_in_4_i,
    // pointers and configuration seen by the array
    output logic [PTR_W-1:0] column_read_pointer_o,
    output logic column_pointer_live_o,
    output logic [PTR_W-1:0] line_read_pointer_o,
    output logic [PTR_W-1:0] line_reset_pointer_o,
    output logic [PTR_W-1:0] line_start_pointer_o,
    output logic [PTR_W-1:0] column_start_pointer_o,
    output logic scan_end_output_o,
    output logic nondestructive_select_o,
    output logic standby_o,
    output logic bias_enable_o,
    output logic gain_stage_calibrate_o,
    output logic [1:0] gain_code_o,
    output logic [5:0] offset_code_o,
    output logic [scp_pkg::CFG_W-1:0] dark_level_o,
    output logic [scp_pkg::CFG_W-1:0] column_trim_o,
    // analog output stand-in and converter
    output logic [PIX_W-1:0] signal_out_o,
    output logic [PIX_W-1:0] converter_word_o,
    output logic converter_ready_o,
    output logic stream_valid_o,
    input wire logic stream_ready_i,
    output logic [PIX_W-1:0] stream_data_o
);
    localparam int LAT = scp_pkg::COLUMN_LATENCY;
    localparam int CNV = scp_pkg::CONV_RISES;

    typedef struct packed {
        logic [scp_pkg::CFG_W-1:0] op;
        logic [scp_pkg::CFG_W-1:0] gain_offset;
        logic [scp_pkg::CFG_W-1:0] dark;
        logic [scp_pkg::CFG_W-1:0] trim;
        logic [PTR_W-1:0] line_start;
        logic [PTR_W-1:0] col_start;
        logic [PTR_W-1:0] line_rd;
        logic [PTR_W-1:0] line_rst;
        logic [PTR_W-1:0] col_rd;
        logic col_live;
        logic col_phase;
        logic write_prev;
        logic colclk_prev;
        logic convclk_prev;
        logic [LAT-1:0][PIX_W-1:0] pix_pipe;
        logic [PIX_W-1:0] signal_out;
        logic [CNV:0][PIX_W-1:0] conv_pipe;
        logic [PIX_W-1:0] conv_word;
        logic conv_strobe;
    } scp_state_t;

    scp_state_t s;
    scp_state_t next_s;
    logic write_rise;
    logic colclk_rise;
    logic conv_rise;
    logic conv_fall;
    logic [2:0] mux_sel;
    logic [1:0] scan_sel;
    logic standby;
    logic [PIX_W-1:0] selected;

    assign write_rise = config_write_strobe_i && !s.write_prev;
    assign colclk_rise = column_clock_i && !s.colclk_prev;
    assign conv_rise = converter_clock_i && !s.convclk_prev;
    assign conv_fall = !converter_clock_i && s.convclk_prev;
    assign mux_sel = s.op[scp_pkg::OP_MUX_MSB:scp_pkg::OP_MUX_LSB];
    assign scan_sel = s.op[scp_pkg::OP_SCAN_MSB:scp_pkg::OP_SCAN_LSB];
    assign standby = s.op[scp_pkg::OP_STANDBY_BIT];

    // unused codes and standby give a flat zero so a stale source cannot leak out
    always_comb begin
        selected = '0;
        case (mux_sel)
            scp_pkg::MUX_PIXEL: selected = s.pix_pipe[LAT-1];
            scp_pkg::MUX_TEMP: selected = temp_value_i;
            scp_pkg::MUX_AUX1: selected = aux_analog_in_1_i;
            scp_pkg::MUX_AUX2: selected = aux_analog_in_2_i;
            scp_pkg::MUX_AUX3: selected = aux_analog_in_3_i;
            scp_pkg::MUX_AUX4: selected = aux_analog_in_4_i;
            default: selected = '0;
        endcase
        if (standby) begin
            selected = '0;
        end
    end

    always_comb begin
        next_s = s;
        next_s.write_prev = config_write_strobe_i;
        next_s.colclk_prev = column_clock_i;
        next_s.convclk_prev = converter_clock_i;
        next_s.conv_strobe = 1'b0;

        // start pointers follow the bus while their strobe is high
        if (line_start_strobe_i) begin
            next_s.line_start = addr_data_i;
        end
        if (column_start_strobe_i) begin
            next_s.col_start = addr_data_i;
        end

        // configuration registers: edge triggered, reset wins over a write
        if (!config_reset_n_i) begin
            next_s.op = scp_pkg::CFG_RESET_VAL;
            next_s.gain_offset = scp_pkg::CFG_RESET_VAL;
            next_s.dark = scp_pkg::CFG_RESET_VAL;
            next_s.trim = scp_pkg::CFG_RESET_VAL;
        end else if (write_rise) begin
            case (addr_data_i[scp_pkg::SEL_MSB:scp_pkg::SEL_LSB])
                scp_pkg::REG_OPERATING: next_s.op = addr_data_i[scp_pkg::CFG_W-1:0];
                scp_pkg::REG_GAIN_OFFSET: next_s.gain_offset = addr_data_i[scp_pkg::CFG_W-1:0];
                scp_pkg::REG_DARK_LEVEL: next_s.dark = addr_data_i[scp_pkg::CFG_W-1:0];
                scp_pkg::REG_COLUMN_TRIM: next_s.trim = addr_data_i[scp_pkg::CFG_W-1:0];
                default: next_s.op = s.op;
            endcase
        end

        // line pointers, advanced one position at a time; wrap past the last line
        if (line_pointer_init_i) begin
            next_s.line_rd = s.line_start;
            next_s.line_rst = s.line_start;
        end else begin
            if (line_read_advance_i) begin
                next_s.line_rd = PTR_W'(s.line_rd + 1'b1);
            end
            if (line_reset_advance_i) begin
                next_s.line_rst = PTR_W'(s.line_rst + 1'b1);
            end
        end

        // column pointer: blanking empties the one-hot register, the first
        // column clock after it reloads the start (the resync), then every
        // second rising edge moves one pixel on
        if (blank_i) begin
            next_s.col_live = 1'b0;
            next_s.col_phase = 1'b0;
        end else if (colclk_rise) begin
            if (!s.col_live) begin
                next_s.col_live = 1'b1;
                next_s.col_rd = s.col_start;
                next_s.col_phase = 1'b0;
            end else begin
                next_s.col_phase = !s.col_phase;
                if (s.col_phase) begin
                    next_s.col_rd = PTR_W'(s.col_rd + 1'b1);
                end
            end
        end

        // output delay line moves only on column clock edges, so a halted
        // clock holds the last presented pixel and resumes without a skip
        if (colclk_rise) begin
            next_s.pix_pipe = {s.pix_pipe[LAT-2:0], pixel_value_i};
        end
        next_s.signal_out = selected;

        // converter: sample on rise, present the sample six rises back on fall
        if (conv_rise) begin
            next_s.conv_pipe = {s.conv_pipe[CNV-1:0], s.signal_out};
        end
        if (conv_fall) begin
            next_s.conv_word = s.conv_pipe[CNV];
            next_s.conv_strobe = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // converter cannot stall; a full buffer shows on converter_ready_o
    scp_word_buffer #(
        .WIDTH(PIX_W),
        .DEPTH(scp_pkg::BUF_DEPTH)
    ) u_buffer (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(s.conv_strobe),
        .in_ready_o(converter_ready_o),
        .in_data_i(s.conv_word),
        .out_valid_o(stream_valid_o),
        .out_ready_i(stream_ready_i),
        .out_data_o(stream_data_o)
    );

    always_comb begin
        case (scan_sel)
            scp_pkg::SCAN_LINE_READ: scan_end_output_o = (s.line_rd == scp_pkg::PTR_LAST);
            scp_pkg::SCAN_LINE_RESET: scan_end_output_o = (s.line_rst == scp_pkg::PTR_LAST);
            default: scan_end_output_o = s.col_live && (s.col_rd == scp_pkg::PTR_LAST);
        endcase
    end

    assign column_read_pointer_o = s.col_rd;
    assign column_pointer_live_o = s.col_live;
    assign line_read_pointer_o = s.line_rd;
    assign line_reset_pointer_o = s.line_rst;
    assign line_start_pointer_o = s.line_start;
    assign column_start_pointer_o = s.col_start;
    assign nondestructive_select_o = s.op[scp_pkg::OP_NDR_BIT];
    assign standby_o = standby;
    assign bias_enable_o = !standby;
    assign gain_stage_calibrate_o = calibrate_i && !standby;
    assign gain_code_o = s.gain_offset[scp_pkg::GAIN_MSB:scp_pkg::GAIN_LSB];
    assign offset_code_o = s.gain_offset[scp_pkg::OFFS_MSB:scp_pkg::OFFS_LSB];
    assign dark_level_o = s.dark;
    assign column_trim_o = s.trim;
    assign signal_out_o = s.signal_out;
    assign converter_word_o = s.conv_word;
endmodule

`default_nettype wire

// file: src/scp_pkg.sv
// constants of the sensor control and programming block
// assumes one 100 mhz clock; every pin input is already synchronous to it
// What this block does
// - pixel appears at output six column clocks after column pointer advances
// - blanking clears column shift register; controller resyncs before reading pixels
// - mux select: 000 pixel, 001 temperature, 100-111 aux inputs, 010/011 unused
// - while column clock halts, output holds last presented pixel
// - column clock resumes on rising edge; next pixel follows, none skipped
// - converter samples on rising edge, updates output on falling edge
// - converter delivers each sample six and a half clock cycles later
// - programming port: ten-bit bus plus line, column and config strobes
// - line and column strobes load all ten bus bits into start pointers
// - start pointers are latches, transparent while strobe is high
// - config write rising edge: bits 9:8 pick register, low byte stored
// - config registers change only on config write rising edge or while config reset is low
// - config reset low clears four config registers, start pointers untouched
// - operating: scan-end 6:5, mux 4:2, bit 1 nondestructive, bit 0 standby
// - start pointers take 0 to 1023, start of one-hot shift registers
// - scan-end: 00 line read, 01 line reset, 10/11 column read pointer
// - gain/offset: offset 7:2, gain 1:0 selecting 1, 2, 4, 8
// - standby disables column bias, amplifier, output buffer, offset converters

package scp_pkg;
    localparam int BUS_W = 10;
    localparam int CFG_W = 8;
    localparam int SEL_MSB = 9;
    localparam int SEL_LSB = 8;

    localparam logic [1:0] REG_OPERATING = 2'h0;
    localparam logic [1:0] REG_GAIN_OFFSET = 2'h1;
    localparam logic [1:0] REG_DARK_LEVEL = 2'h2;
    localparam logic [1:0] REG_COLUMN_TRIM = 2'h3;
    localparam logic [7:0] CFG_RESET_VAL = 8'h00;
    localparam logic [9:0] PTR_RESET_VAL = 10'h000;
    localparam logic [9:0] PTR_LAST = 10'h3ff;

    localparam int OP_STANDBY_BIT = 0;
    localparam int OP_NDR_BIT = 1;
    localparam int OP_MUX_LSB = 2;
    localparam int OP_MUX_MSB = 4;
    localparam int OP_SCAN_LSB = 5;
    localparam int OP_SCAN_MSB = 6;
    localparam int GAIN_LSB = 0;
    localparam int GAIN_MSB = 1;
    localparam int OFFS_LSB = 2;
    localparam int OFFS_MSB = 7;

    localparam logic [2:0] MUX_PIXEL = 3'h0;
    localparam logic [2:0] MUX_TEMP = 3'h1;
    localparam logic [2:0] MUX_AUX1 = 3'h4;
    localparam logic [2:0] MUX_AUX2 = 3'h5;
    localparam logic [2:0] MUX_AUX3 = 3'h6;
    localparam logic [2:0] MUX_AUX4 = 3'h7;
    localparam logic [1:0] SCAN_LINE_READ = 2'h0;
    localparam logic [1:0] SCAN_LINE_RESET = 2'h1;

    // column clock cycles from pointer advance to output
    localparam int COLUMN_LATENCY = 6;
    // whole converter rising edges before the output falling edge (6.5 cycles)
    localparam int CONV_RISES = 6;
    localparam int BUF_DEPTH = 2;
endpackage

// file: src/scp_word_buffer.sv
// two-entry word buffer with valid/ready on both sides
// assumes a synchronous active-low reset; read data come from a register

`timescale 1ns/1ps
`default_nettype none

module scp_word_buffer #(
    parameter int WIDTH = 12,
    parameter int DEPTH = scp_pkg::BUF_DEPTH
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] count;
    } scp_buf_state_t;

    scp_buf_state_t s;
    scp_buf_state_t next_s;
    logic push;
    logic pop;

    assign in_ready_o = (s.count != CW'(DEPTH));
    assign out_valid_o = (s.count != '0);
    assign out_data_o = s.mem[s.rd];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr] = in_data_i;
            next_s.wr = (s.wr == PW'(DEPTH - 1)) ? '0 : PW'(s.wr + 1'b1);
        end
        if (pop) begin
            next_s.rd = (s.rd == PW'(DEPTH - 1)) ? '0 : PW'(s.rd + 1'b1);
        end
        if (push && !pop) begin
            next_s.count = CW'(s.count + 1'b1);
        end else if (pop && !push) begin
            next_s.count = CW'(s.count - 1'b1);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

`default_nettype wire

// file: bench/scp_sensor_control_properties.sv
// checker of the sensor control block, bound to its top ports
// assumes the single clock domain and the synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module scp_sensor_control_properties #(
    parameter int PIX_W = 12,
    parameter int PTR_W = scp_pkg::BUS_W
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [scp_pkg::BUS_W-1:0] addr_data_i,
    input wire logic line_start_strobe_i,
    input wire logic column_start_strobe_i,
    input wire logic config_write_strobe_i,
    input wire logic config_reset_n_i,
    input wire logic converter_clock_i,
    input wire logic stream_ready_i,
    input wire logic [PTR_W-1:0] line_start_pointer_o,
    input wire logic [PTR_W-1:0] column_start_pointer_o,
    input wire logic standby_o,
    input wire logic bias_enable_o,
    input wire logic gain_stage_calibrate_o,
    input wire logic [1:0] gain_code_o,
    input wire logic [5:0] offset_code_o,
    input wire logic [scp_pkg::CFG_W-1:0] dark_level_o,
    input wire logic [scp_pkg::CFG_W-1:0] column_trim_o,
    input wire logic [PIX_W-1:0] converter_word_o,
    input wire logic stream_valid_o,
    input wire logic [PIX_W-1:0] stream_data_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence cfg_edge_s;
        $rose(config_write_strobe_i) && config_reset_n_i;
    endsequence

    line_load_a: assert property (line_start_strobe_i |=> line_start_pointer_o == $past(addr_data_i))
        else $error("line start pointer did not follow the bus");
    col_load_a: assert property (column_start_strobe_i |=> column_start_pointer_o == $past(addr_data_i))
        else $error("column start pointer did not follow the bus");
    col_hold_a: assert property (!column_start_strobe_i |=> $stable(column_start_pointer_o))
        else $error("column start pointer moved without strobe");
    trim_write_a: assert property (cfg_edge_s ##0 (addr_data_i[9:8] == 2'h3)
        |=> column_trim_o == $past(addr_data_i[7:0]))
        else $error("trim register not written");
    gain_write_a: assert property (cfg_edge_s ##0 (addr_data_i[9:8] == scp_pkg::REG_GAIN_OFFSET)
        |=> {offset_code_o, gain_code_o} == $past(addr_data_i[7:0]))
        else $error("gain offset register not written");
    cfg_stable_a: assert property (!config_write_strobe_i && config_reset_n_i
        |=> $stable(dark_level_o) && $stable(column_trim_o))
        else $error("config register changed without write edge");
    cfg_clear_a: assert property (!config_reset_n_i |=> dark_level_o == 8'h00 && column_trim_o == 8'h00
        && gain_code_o == 2'h0 && offset_code_o == 6'h00)
        else $error("config reset did not clear registers");
    standby_off_a: assert property (standby_o |-> !bias_enable_o && !gain_stage_calibrate_o)
        else $error("standby left bias or calibrate on");
    conv_update_a: assert property ($changed(converter_word_o)
        |-> $past(converter_clock_i, 2) && !$past(converter_clock_i))
        else $error("converter word changed off a falling edge");
    stream_hold_a: assert property (stream_valid_o && !stream_ready_i |=> stream_valid_o && $stable(stream_data_o))
        else $error("stalled stream word lost");
endmodule

bind scp_sensor_control scp_sensor_control_properties #(.PIX_W(PIX_W), .PTR_W(PTR_W)) props (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_data_i(addr_data_i),
    .line_start_strobe_i(line_start_strobe_i), .column_start_strobe_i(column_start_strobe_i),
    .config_write_strobe_i(config_write_strobe_i), .config_reset_n_i(config_reset_n_i),
    .converter_clock_i(converter_clock_i), .stream_ready_i(stream_ready_i),
    .line_start_pointer_o(line_start_pointer_o), .column_start_pointer_o(column_start_pointer_o),
    .standby_o(standby_o), .bias_enable_o(bias_enable_o), .gain_stage_calibrate_o(gain_stage_calibrate_o),
    .gain_code_o(gain_code_o), .offset_code_o(offset_code_o), .dark_level_o(dark_level_o),
    .column_trim_o(column_trim_o), .converter_word_o(converter_word_o), .stream_valid_o(stream_valid_o),
    .stream_data_o(stream_data_o)
);
`default_nettype wire

// file: bench/scp_controller_model.sv
// external controller model: column clock, converter clock, calibrate
// assumes run requests are changed by non-blocking assignment at the falling edge
`timescale 1ns/1ps
`default_nettype none
module scp_controller_model (
    input wire logic clock_i,
    input wire logic col_run_i,
    input wire logic conv_run_i,
    input wire logic blank_i,
    input wire logic cal_req_i,
    output logic column_clock_o,
    output logic converter_clock_o,
    output logic calibrate_o
);
    initial begin
        column_clock_o = 1'b0;
        converter_clock_o = 1'b0;
    end
    // blanking doubles as calibrate; extra pulses serve gain changes without blanking
    assign calibrate_o = blank_i | cal_req_i;
    // a halted clock parks low, so a restart always begins with a rising edge
    always @(negedge clock_i) begin
        if (col_run_i || column_clock_o) begin
            column_clock_o <= !column_clock_o;
        end
        if (conv_run_i || converter_clock_o) begin
            converter_clock_o <= !converter_clock_o;
        end
    end
endmodule
`default_nettype wire

// file: bench/scp_sensor_control_tb.sv
// bench of the sensor control block: programming port, mux, column path, converter, stream
// assumes the controller model drives the column and converter clocks
`timescale 1ns/1ps
`default_nettype none
module scp_sensor_control_tb;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [9:0] bus = 10'h000;
    logic ld_line = 1'b0, ld_col = 1'b0, ld_cfg = 1'b0, cfg_rst_n = 1'b1, blank = 1'b0, cal_req = 1'b0;
    logic col_run = 1'b0, conv_run = 1'b0, line_init = 1'b0, rd_adv = 1'b0, ready = 1'b1;
    logic column_clock, conv_clock, calibrate, live, scan_end, nondestructive_select, standby, bias, cal_o, conv_rdy, s_valid;
    logic [9:0] col_rd, line_ptr, col_ptr;
    logic [1:0] gain;
    logic [5:0] offs;
    logic [7:0] dark, trim;
    logic [11:0] src = 12'h000;
    logic [11:0] pixel, sig, word, s_data, hold_val;
    logic [11:0] pq[$], cq[$], sq[$];
    logic col_prev = 1'b0, conv_prev = 1'b0, fall_seen = 1'b0;
    int n_fail = 0, check_count = 0, rise_cnt = 0;

    always #5 clock_i = !clock_i;
    // the array stand-in: each column gives its own value
    assign pixel = {2'h0, col_rd} ^ 12'h5a0;

    scp_controller_model ctrl (.clock_i(clock_i), .col_run_i(col_run), .conv_run_i(conv_run), .blank_i(blank),
        .cal_req_i(cal_req), .column_clock_o(column_clock), .converter_clock_o(conv_clock), .calibrate_o(calibrate));

    scp_sensor_control uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_data_i(bus),
        .line_start_strobe_i(ld_line), .column_start_strobe_i(ld_col), .config_write_strobe_i(ld_cfg),
        .config_reset_n_i(cfg_rst_n), .column_clock_i(column_clock), .blank_i(blank), .calibrate_i(calibrate),
        .line_pointer_init_i(line_init), .line_read_advance_i(rd_adv), .line_reset_advance_i(1'b0),
        .converter_clock_i(conv_clock), .pixel_value_i(pixel), .temp_value_i(src), .aux_analog_in_1_i(src + 12'h1),
        .aux_analog_in_2_i(src + 12'h2), .aux_analog_in_3_i(src + 12'h3), .aux_analog_in_4_i(src + 12'h4),
        .column_read_pointer_o(col_rd), .column_pointer_live_o(live), .line_read_pointer_o(),
        .line_reset_pointer_o(), .line_start_pointer_o(line_ptr), .column_start_pointer_o(col_ptr),
        .scan_end_output_o(scan_end), .nondestructive_select_o(nondestructive_select), .standby_o(standby), .bias_enable_o(bias),
        .gain_stage_calibrate_o(cal_o), .gain_code_o(gain), .offset_code_o(offs), .dark_level_o(dark),
        .column_trim_o(trim), .signal_out_o(sig), .converter_word_o(word), .converter_ready_o(conv_rdy),
        .stream_valid_o(s_valid), .stream_ready_i(ready), .stream_data_o(s_data));

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    task automatic ld_ptr(input logic col, input logic [9:0] v);
        bus = v;
        ld_col = col;
        ld_line = !col;
        cyc(1);
        ld_col = 1'b0;
        ld_line = 1'b0;
        bus = ~v;
        cyc(1);
    endtask

    task automatic wr_cfg(input logic [1:0] s, input logic [7:0] d);
        bus = {s, d};
        ld_cfg = 1'b1;
        cyc(1);
        ld_cfg = 1'b0;
        cyc(2);
    endtask

    task automatic run_cols(input int n);
        int t;
        t = rise_cnt + n;
        col_run <= 1'b1;
        for (int i = 0; i < 500 && rise_cnt < t; i++) cyc(1);
        if (rise_cnt < t) n_fail++;
        col_run <= 1'b0;
        cyc(3);
    endtask

    // outputs are read before this edge's updates land, as the block samples them
    always @(posedge clock_i) begin
        if (column_clock && !col_prev) begin
            rise_cnt++;
            pq.push_back(pixel);
            if (pq.size() > 6) chk_val("pixel out", pq[pq.size()-7], sig);
        end
        if (fall_seen && cq.size() > 6) chk_val("converter word", cq[cq.size()-7], word);
        // a word offered while the buffer is full is dropped, so only accepted words are expected
        if (fall_seen && conv_rdy) sq.push_back((cq.size() > 6) ? cq[cq.size()-7] : 12'h000);
        if (s_valid && ready) begin
            chk_val("stream word", (sq.size() > 0) ? {20'h0, sq[0]} : 32'h1000, s_data);
            if (sq.size() > 0) sq.delete(0);
        end
        if (conv_clock && !conv_prev) cq.push_back(sig);
        fall_seen <= conv_prev && !conv_clock;
        col_prev <= column_clock;
        conv_prev <= conv_clock;
    end

    initial begin
        #50000;
        n_fail++;
        print_verdict;
    end

    initial begin
        cyc(10);
        rst_n_i = 1'b1;
        cyc(1);
        chk_val("config after reset", 32'h1, {gain, offs, dark, trim, standby, bias});
        ld_ptr(1'b0, 10'h3ff);
        chk_val("line start", 32'h3ff, line_ptr);
        ld_ptr(1'b1, 10'h038);
        chk_val("column start", 32'h038, col_ptr);
        wr_cfg(2'h1, 8'h9e);
        chk_val("gain offset", 32'h9e, {offs, gain});
        wr_cfg(2'h2, 8'h81);
        chk_val("dark level", 32'h81, dark);
        bus = 10'h3c3;
        ld_cfg = 1'b1;
        cyc(1);
        bus = 10'h37e;
        cyc(2);
        ld_cfg = 1'b0;
        chk_val("trim held strobe", 32'hc3, trim);
        cyc(1);
        wr_cfg(2'h0, 8'h03);
        cal_req = 1'b1;
        cyc(1);
        chk_val("standby", 32'hc, {standby, nondestructive_select, bias, cal_o});
        cal_req = 1'b0;
        cfg_rst_n = 1'b0;
        cyc(1);
        cfg_rst_n = 1'b1;
        cyc(1);
        chk_val("config clear", 32'h1, {gain, offs, dark, trim, standby, bias});
        chk_val("pointers kept", 32'hffc38, {line_ptr, col_ptr});
        for (int c = 1; c < 8; c++) begin
            src = 12'(c * 256 + 5);
            wr_cfg(2'h0, {3'h0, 3'(c), 2'h0});
            chk_val("mux output", (c == 1) ? src : (c > 3) ? src + 12'(c - 3) : 12'h0, sig);
        end
        line_init = 1'b1;
        cyc(1);
        line_init = 1'b0;
        wr_cfg(2'h0, 8'h00);
        chk_val("scan end line read", 32'h1, scan_end);
        rd_adv = 1'b1;
        cyc(1);
        rd_adv = 1'b0;
        cyc(1);
        chk_val("scan end line read", 32'h0, scan_end);
        wr_cfg(2'h0, 8'h20);
        chk_val("scan end line reset", 32'h1, scan_end);
        wr_cfg(2'h0, 8'h40);
        chk_val("scan end column", 32'h0, scan_end);
        wr_cfg(2'h0, 8'h00);
        blank = 1'b1;
        cyc(2);
        chk_val("live after blank", 32'h1, {live, calibrate});
        blank = 1'b0;
        conv_run <= 1'b1;
        run_cols(9);
        chk_val("column pointer", 32'h43c, {live, col_rd});
        hold_val = sig;
        wr_cfg(2'h1, 8'h01);
        cal_req = 1'b1;
        cyc(20);
        cal_req = 1'b0;
        cyc(5);
        chk_val("halted output", hold_val, sig);
        run_cols(20);
        ready = 1'b0;
        cyc(60);
        chk_val("stalled buffer", 32'h2, {s_valid, conv_rdy});
        ready = 1'b1;
        conv_run <= 1'b0;
        cyc(20);
        chk_val("drained buffer", 32'h1, {s_valid, conv_rdy});
        chk_val("stream left", 32'h0, sq.size());
        blank = 1'b1;
        cyc(2);
        chk_val("blank clears live", 32'h1, {live, calibrate});
        blank = 1'b0;
        print_verdict;
    end
endmodule
`default_nettype wire
